// File: core/csi_defs.svh
// Constants for the cpu status, stack and interrupt block.
// Included by the core and bench files; definitions only.
`ifndef CSI_DEFS_SVH
`define CSI_DEFS_SVH
`define CSI_FLAG_C 3'd0
`define CSI_FLAG_Z 3'd1
`define CSI_FLAG_N 3'd2
`define CSI_FLAG_V 3'd3
`define CSI_FLAG_S 3'd4
`define CSI_FLAG_H 3'd5
`define CSI_FLAG_T 3'd6
`define CSI_FLAG_I 3'd7
`define CSI_ADDR_FLAGS 12'h000
`define CSI_ADDR_SP_LO 12'h004
`define CSI_ADDR_SP_HI 12'h008
`define CSI_ADDR_IRQ_EN 12'h00c
`define CSI_ADDR_IRQ_FLAG 12'h010
`define CSI_ADDR_CTRL 12'h014
`define CSI_ADDR_STATE 12'h018
`define CSI_RST_FLAGS 8'h00
`define CSI_RST_SP 8'h00
`define CSI_ENTRY_NS 400
`define CSI_CLK_NS 100
`define CSI_ENTRY_CYC ((`CSI_ENTRY_NS + `CSI_CLK_NS - 1) / `CSI_CLK_NS)
`endif

// File: core/csi_pkg.sv
// Types for the cpu status, stack and interrupt block.
// No constants here; those live in csi_defs.svh.
package csi_pkg;
  typedef enum logic [3:0] {
    CSI_OP_NONE = 4'b0000,
    CSI_OP_PUSH = 4'b0001,
    CSI_OP_POP = 4'b0010,
    CSI_OP_CALL = 4'b0011,
    CSI_OP_RET = 4'b0100,
    CSI_OP_IRQ_RET = 4'b0101,
    CSI_OP_CLI = 4'b0110,
    CSI_OP_SEI = 4'b0111,
    CSI_OP_BIT_STORE = 4'b1000,
    CSI_OP_BIT_LOAD = 4'b1001
  } csi_op_e;
  typedef enum logic [1:0] {
    CSI_ST_RUN = 2'b00,
    CSI_ST_ENTRY = 2'b01,
    CSI_ST_SHADOW = 2'b10
  } csi_state_e;
endpackage

// File: core/csi_regfile.sv
// 32 x 8 working register file with two read ports and a
// byte or word write port. Writes land on the rising clock edge.
`timescale 1ns/1ps
module csi_regfile #(
  parameter int NREG = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Read ports
  input wire logic [4:0] rd_a_idx,
  input wire logic [4:0] rd_b_idx,
  output logic [7:0] rd_a,
  output logic [7:0] rd_b,
  output logic [15:0] rd_word,
  // Write port
  input wire logic wr_en,
  input wire logic wr_wide,
  input wire logic [4:0] wr_idx,
  input wire logic [15:0] wr_data,
  // Pointers
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z
);
  logic [7:0] regs [NREG];
  logic [4:0] wr_hi_idx;

  // Word accesses use an even pair, low byte first
  assign wr_hi_idx = {wr_idx[4:1], 1'b1};
  assign rd_a = regs[rd_a_idx];
  assign rd_b = regs[rd_b_idx];
  assign rd_word = {regs[{rd_a_idx[4:1], 1'b1}], regs[{rd_a_idx[4:1], 1'b0}]};
  assign ptr_x = {regs[27], regs[26]};
  assign ptr_y = {regs[29], regs[28]};
  assign ptr_z = {regs[31], regs[30]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (wr_en) begin
      if (wr_wide) begin
        regs[{wr_idx[4:1], 1'b0}] <= wr_data[7:0];
        regs[wr_hi_idx] <= wr_data[15:8];
      end else begin
        regs[wr_idx] <= wr_data[7:0];
      end
    end
  end
endmodule // csi_regfile

// File: core/csi_core.sv
// Status flags, register file port, stack pointer and interrupt
// controller, with an APB slave for the software-visible registers.
// Assumes a sequencer issuing one op per cycle and holding while busy.
//
// Operation
// - T flag at bit 6; bit store copies register bit in, load copies out.
// - Half carry at bit 5 records low-nibble carry where defined.
// - Sign at bit 4 is always N xor V.
// - Overflow at bit 3 follows signed overflow of the result.
// - N bit 2, Z bit 1, C bit 0 follow ALU or logic results.
// - Register file supports 8/8, 2x8/8, 2x8/16 and 16/16 schemes.
// - R26 to R31 form X, Y, Z 16-bit pointers.
// - Stack grows down; push decrements by one, pop increments by one.
// - Call or interrupt entry subtracts two; returns add two.
// - Stack pointer visible as high and low 8-bit read/write registers.
// - Two-operand ALU result is written back in one clock.
// - Interrupt accepted only with its enable and global enable set.
// - Lower vector index has higher priority; reset vector lowest.
// - Vectors move to boot start by select bit; reset by fuse.
// - Boot lock bits can block interrupts based on program counter.
// - Acceptance clears global enable; interrupt return sets it.
// - Flag sources clear on vectoring and on software write of one.
// - Flags stay pending while disabled, served later in priority order.
// - Level sources request only while their condition is present.
// - After return one instruction runs first; flags not saved.
// - Interrupt disable acts at once, even on a same-cycle request.
// - Global enable at bit 7; clear masks every source.
// - At least four cycles from acceptance to vector execution.
`timescale 1ns/1ps
`include "csi_defs.svh"
module csi_core #(
  parameter int NIRQ = 8,
  parameter int PC_W = 13,
  parameter int SP_W = 16,
  parameter logic [PC_W-1:0] BOOT_START = 13'h1c00,
  parameter logic [NIRQ-1:0] LEVEL_MASK = 8'h00
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer op
  input wire logic op_valid,
  input wire csi_pkg::csi_op_e op_code,
  input wire logic instr_done,
  input wire logic [PC_W-1:0] pc,
  // ALU result and flag update
  input wire logic alu_wr,
  input wire logic alu_wide,
  input wire logic [4:0] alu_dst,
  input wire logic [15:0] alu_result,
  input wire logic [7:0] alu_flag_mask,
  input wire logic alu_c,
  input wire logic alu_z,
  input wire logic alu_n,
  input wire logic alu_v,
  input wire logic alu_h,
  // Register file read and bit select
  input wire logic [4:0] rd_a_idx,
  input wire logic [4:0] rd_b_idx,
  input wire logic [2:0] bit_sel,
  output logic [7:0] rd_a,
  output logic [7:0] rd_b,
  output logic [15:0] rd_word,
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z,
  // Interrupt sources and straps
  input wire logic [NIRQ-1:0] irq_event,
  input wire logic [NIRQ-1:0] irq_level,
  input wire logic boot_reset_fuse,
  input wire logic app_lock_bit,
  input wire logic boot_lock_bit,
  // Interrupt and stack results
  output logic irq_take,
  output logic [PC_W-1:0] irq_vector,
  output logic [PC_W-1:0] reset_vector,
  output logic seq_busy,
  output logic [SP_W-1:0] stack_ptr,
  output logic [7:0] cpu_flags_out
);
  localparam int IDX_W = $clog2(NIRQ + 1);
  localparam logic [2:0] ENTRY_LAST = 3'(`CSI_ENTRY_CYC - 1);

  logic [7:0] cpu_flags;
  logic [7:0] stack_pointer_low;
  logic [7:0] stack_pointer_high;
  logic [NIRQ-1:0] irq_enable;
  logic [NIRQ-1:0] irq_flag;
  logic vector_relocate_bit;
  csi_pkg::csi_state_e state;
  logic [2:0] entry_cnt;
  logic [IDX_W-1:0] held_idx;
  logic [31:0] prdata_q;

  logic [7:0] next_flags;
  logic [SP_W-1:0] next_sp;
  logic [NIRQ-1:0] next_flag;

  // Fixed priority: lowest index wins
  function automatic logic [IDX_W-1:0] pick_lowest(
    input logic [NIRQ-1:0] req
  );
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit_flags = paddr == `CSI_ADDR_FLAGS;
  wire hit_sp_lo = paddr == `CSI_ADDR_SP_LO;
  wire hit_sp_hi = paddr == `CSI_ADDR_SP_HI;
  wire hit_en = paddr == `CSI_ADDR_IRQ_EN;
  wire hit_flag = paddr == `CSI_ADDR_IRQ_FLAG;
  wire hit_ctrl = paddr == `CSI_ADDR_CTRL;
  wire hit_state = paddr == `CSI_ADDR_STATE;
  wire hit_any = hit_flags || hit_sp_lo || hit_sp_hi || hit_en || hit_flag ||
    hit_ctrl || hit_state;

  // Op decode
  wire op_push = op_valid && op_code == csi_pkg::CSI_OP_PUSH;
  wire op_pop = op_valid && op_code == csi_pkg::CSI_OP_POP;
  wire op_call = op_valid && op_code == csi_pkg::CSI_OP_CALL;
  wire op_ret = op_valid && op_code == csi_pkg::CSI_OP_RET;
  wire op_irq_ret = op_valid && op_code == csi_pkg::CSI_OP_IRQ_RET;
  wire op_cli = op_valid && op_code == csi_pkg::CSI_OP_CLI;
  wire op_sei = op_valid && op_code == csi_pkg::CSI_OP_SEI;
  wire op_bit_store = op_valid && op_code == csi_pkg::CSI_OP_BIT_STORE;
  wire op_bit_load = op_valid && op_code == csi_pkg::CSI_OP_BIT_LOAD;

  // Interrupt request qualification
  wire [NIRQ-1:0] src_req = (irq_flag & ~LEVEL_MASK) |
    (irq_level & LEVEL_MASK);
  wire [NIRQ-1:0] armed = src_req & irq_enable;
  wire in_boot = pc >= BOOT_START;
  wire lock_block = in_boot ? boot_lock_bit : app_lock_bit;
  wire gie = cpu_flags[`CSI_FLAG_I];
  wire can_take = gie && !op_cli && !op_irq_ret && instr_done &&
    state == csi_pkg::CSI_ST_RUN && !lock_block;
  wire take_now = can_take && |armed;
  wire [IDX_W-1:0] take_idx = pick_lowest(armed);
  wire [NIRQ-1:0] take_onehot = take_now ?
    NIRQ'(1) << take_idx : '0;
  wire entry_done = state == csi_pkg::CSI_ST_ENTRY &&
    entry_cnt == ENTRY_LAST;

  // Vector base, relocatable
  wire [PC_W-1:0] vec_base = vector_relocate_bit ?
    BOOT_START : '0;
  assign reset_vector = boot_reset_fuse ? BOOT_START : '0;
  assign irq_vector = vec_base + PC_W'({held_idx, 1'b0} + 2);

  // Bit load writes a single bit of the chosen register
  wire [7:0] bit_load_byte = (rd_a & ~(8'h01 << bit_sel)) |
    (8'(cpu_flags[`CSI_FLAG_T]) << bit_sel);
  wire rf_wr = alu_wr || op_bit_load;
  wire rf_wide = alu_wide && !op_bit_load;
  wire [4:0] rf_idx = op_bit_load ? rd_a_idx : alu_dst;
  wire [15:0] rf_data = op_bit_load ? {8'h00, bit_load_byte} :
    alu_result;

  // Flag register next value
  always_comb begin
    next_flags = cpu_flags;
    if (alu_flag_mask[`CSI_FLAG_C]) next_flags[`CSI_FLAG_C] = alu_c;
    if (alu_flag_mask[`CSI_FLAG_Z]) next_flags[`CSI_FLAG_Z] = alu_z;
    if (alu_flag_mask[`CSI_FLAG_N]) next_flags[`CSI_FLAG_N] = alu_n;
    if (alu_flag_mask[`CSI_FLAG_V]) next_flags[`CSI_FLAG_V] = alu_v;
    if (alu_flag_mask[`CSI_FLAG_H]) next_flags[`CSI_FLAG_H] = alu_h;
    if (op_bit_store) next_flags[`CSI_FLAG_T] = rd_a[bit_sel];
    if (apb_wr && hit_flags) next_flags = pwdata[7:0];
    if (op_sei) next_flags[`CSI_FLAG_I] = 1'b1;
    if (op_cli) next_flags[`CSI_FLAG_I] = 1'b0;
    if (op_irq_ret) next_flags[`CSI_FLAG_I] = 1'b1;
    if (take_now) next_flags[`CSI_FLAG_I] = 1'b0;
    next_flags[`CSI_FLAG_S] = next_flags[`CSI_FLAG_N] ^
      next_flags[`CSI_FLAG_V];
  end

  // Stack pointer next value
  always_comb begin
    next_sp = {stack_pointer_high, stack_pointer_low};
    if (apb_wr && hit_sp_lo) next_sp[7:0] = pwdata[7:0];
    if (apb_wr && hit_sp_hi) next_sp[SP_W-1:8] = pwdata[SP_W-9:0];
    if (op_push) next_sp = next_sp - SP_W'(1);
    if (op_pop) next_sp = next_sp + SP_W'(1);
    if (op_call || take_now) next_sp = next_sp - SP_W'(2);
    if (op_ret || op_irq_ret) next_sp = next_sp + SP_W'(2);
  end

  // Event flags: set beats both clears
  always_comb begin
    next_flag = irq_flag;
    if (apb_wr && hit_flag) next_flag = next_flag & ~pwdata[NIRQ-1:0];
    next_flag = next_flag & ~take_onehot;
    next_flag = (next_flag | irq_event) & ~LEVEL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_flags <= `CSI_RST_FLAGS;
      stack_pointer_low <= `CSI_RST_SP;
      stack_pointer_high <= `CSI_RST_SP;
      irq_flag <= '0;
    end else begin
      cpu_flags <= next_flags;
      stack_pointer_low <= next_sp[7:0];
      stack_pointer_high <= next_sp[SP_W-1:8];
      irq_flag <= next_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= '0;
      vector_relocate_bit <= 1'b0;
    end else if (apb_wr && hit_en) begin
      irq_enable <= pwdata[NIRQ-1:0];
    end else if (apb_wr && hit_ctrl) begin
      vector_relocate_bit <= pwdata[0];
    end
  end

  // Entry sequencing; shadow state lets one instruction run after return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= csi_pkg::CSI_ST_RUN;
      entry_cnt <= 3'h0;
      held_idx <= '0;
    end else begin
      unique case (state)
        csi_pkg::CSI_ST_RUN: begin
          if (take_now) begin
            state <= csi_pkg::CSI_ST_ENTRY;
            entry_cnt <= 3'h0;
            held_idx <= take_idx;
          end else if (op_irq_ret) begin
            state <= csi_pkg::CSI_ST_SHADOW;
          end
        end
        csi_pkg::CSI_ST_ENTRY: begin
          entry_cnt <= entry_cnt + 3'h1;
          if (entry_done) state <= csi_pkg::CSI_ST_RUN;
        end
        csi_pkg::CSI_ST_SHADOW: begin
          if (instr_done) state <= csi_pkg::CSI_ST_RUN;
        end
        default: state <= csi_pkg::CSI_ST_RUN;
      endcase
    end
  end

  // Read data registered at setup; answer comes in the access phase
  wire [31:0] rd_mux =
    hit_flags ? {24'h0, cpu_flags} :
    hit_sp_lo ? {24'h0, stack_pointer_low} :
    hit_sp_hi ? {24'h0, stack_pointer_high} :
    hit_en ? 32'(irq_enable) :
    hit_flag ? 32'(irq_flag) :
    hit_ctrl ? {31'h0, vector_relocate_bit} :
    hit_state ? {28'h0, entry_cnt, state == csi_pkg::CSI_ST_ENTRY} :
    32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (apb_setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign irq_take = entry_done;
  assign seq_busy = state == csi_pkg::CSI_ST_ENTRY;
  assign stack_ptr = {stack_pointer_high, stack_pointer_low};
  assign cpu_flags_out = cpu_flags;

  csi_regfile #(
    .NREG(32)
  ) u_regfile (
    .pclk(pclk),
    .presetn(presetn),
    .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx),
    .rd_a(rd_a),
    .rd_b(rd_b),
    .rd_word(rd_word),
    .wr_en(rf_wr),
    .wr_wide(rf_wide),
    .wr_idx(rf_idx),
    .wr_data(rf_data),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .ptr_z(ptr_z)
  );
endmodule // csi_core

// File: verification/csi_core_checker.sv
// Port assertions for csi_core, bound to every instance.
// Assumes one pclk domain and an active-low presetn.
`timescale 1ns/1ps
module csi_core_checker #(
  parameter int PC_W = 13,
  parameter int SP_W = 16,
  parameter logic [PC_W-1:0] BOOT_START = 13'h1c00
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencer and straps
  input wire logic op_valid,
  input wire csi_pkg::csi_op_e op_code,
  input wire logic instr_done,
  input wire logic [PC_W-1:0] pc,
  input wire logic boot_reset_fuse,
  input wire logic app_lock_bit,
  input wire logic boot_lock_bit,
  // Results
  input wire logic irq_take,
  input wire logic [PC_W-1:0] reset_vector,
  input wire logic seq_busy,
  input wire logic [SP_W-1:0] stack_ptr,
  input wire logic [7:0] cpu_flags_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Acceptance would also move SP, so keep it out
  wire quiet = op_valid && !instr_done && !seq_busy;
  wire locked = (pc < BOOT_START) ? app_lock_bit : boot_lock_bit;
  chk_sign_xor: assert property (
    cpu_flags_out[4] == (cpu_flags_out[2] ^ cpu_flags_out[3]))
    else $error("sign flag is not n xor v");
  chk_entry_len: assert property (
    $rose(seq_busy) |-> (seq_busy && !irq_take)[*3]
      ##1 (seq_busy && irq_take) ##1 !seq_busy)
    else $error("entry sequence has wrong length");
  chk_entry_clr_i: assert property (
    $rose(seq_busy) |-> !cpu_flags_out[7])
    else $error("global enable still set in entry");
  chk_cli_now: assert property (
    op_valid && op_code == csi_pkg::CSI_OP_CLI
      |=> !cpu_flags_out[7] && !$rose(seq_busy) ##1 !$rose(seq_busy))
    else $error("interrupt taken across disable");
  chk_push_dec: assert property (
    quiet && op_code == csi_pkg::CSI_OP_PUSH
      |=> stack_ptr == $past(stack_ptr) - 1'b1)
    else $error("push did not lower sp by one");
  chk_call_dec: assert property (
    quiet && op_code == csi_pkg::CSI_OP_CALL
      |=> stack_ptr == $past(stack_ptr) - 2'd2)
    else $error("call did not lower sp by two");
  chk_lock_block: assert property (
    locked[*3] |-> !$rose(seq_busy))
    else $error("interrupt taken while locked");
  chk_reset_vec: assert property (
    reset_vector == (boot_reset_fuse ? BOOT_START : '0))
    else $error("reset vector ignores fuse");
endmodule // csi_core_checker
bind csi_core csi_core_checker #(.PC_W(PC_W), .SP_W(SP_W),
  .BOOT_START(BOOT_START)) i_csi_core_checker (.pclk, .presetn,
  .op_valid, .op_code, .instr_done, .pc, .boot_reset_fuse,
  .app_lock_bit, .boot_lock_bit, .irq_take, .reset_vector, .seq_busy,
  .stack_ptr, .cpu_flags_out);

// File: verification/csi_seq_model.sv
// Sequencer and event-source model facing csi_core.
// The bench calls issue; it never issues while an entry runs.
`timescale 1ns/1ps
module csi_seq_model (
  // Clock
  input wire logic pclk,
  // Op and events
  output logic op_valid,
  output csi_pkg::csi_op_e op_code,
  output logic instr_done,
  output logic [7:0] irq_event
);
  initial begin
    op_valid = 1'b0;
    op_code = csi_pkg::CSI_OP_NONE;
    instr_done = 1'b0;
    irq_event = 8'h00;
  end
  // Idle cycle after each op keeps events single-cycle pulses
  task automatic issue(input csi_pkg::csi_op_e c, input logic d,
      input logic [7:0] e);
    @(posedge pclk);
    op_valid <= c != csi_pkg::CSI_OP_NONE;
    op_code <= c;
    instr_done <= d;
    irq_event <= e;
    @(posedge pclk);
    op_valid <= 1'b0;
    op_code <= csi_pkg::CSI_OP_NONE;
    instr_done <= 1'b0;
    irq_event <= 8'h00;
  endtask
endmodule // csi_seq_model

// File: verification/csi_core_tb_top.sv
// Self-checking bench for csi_core over APB, ALU and sequencer.
// Assumes csi_seq_model as sequencer and the bound checker.
`timescale 1ns/1ps
`include "csi_defs.svh"
module csi_core_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic op_valid, instr_done, alu_wr, alu_wide, alu_c, alu_z, alu_n;
  logic alu_v, alu_h, boot_reset_fuse, app_lock_bit, irq_take, seq_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  csi_pkg::csi_op_e op_code;
  logic [4:0] alu_dst, rd_a_idx;
  logic [2:0] bit_sel;
  logic [15:0] alu_result, rd_word, ptr_x, stack_ptr;
  logic [7:0] alu_flag_mask, irq_event, cpu_flags_out;
  logic [12:0] irq_vector, reset_vector;
  int errors = 0;
  int checks = 0;
  csi_core i_csi_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code, .instr_done,
    .pc(13'h0000), .alu_wr, .alu_wide, .alu_dst, .alu_result,
    .alu_flag_mask, .alu_c, .alu_z, .alu_n, .alu_v, .alu_h, .rd_a_idx,
    .rd_b_idx(5'h00), .bit_sel, .rd_a(), .rd_b(), .rd_word, .ptr_x,
    .ptr_y(), .ptr_z(), .irq_event, .irq_level(8'h00), .boot_reset_fuse,
    .app_lock_bit, .boot_lock_bit(1'b0), .irq_take, .irq_vector,
    .reset_vector, .seq_busy, .stack_ptr, .cpu_flags_out);
  csi_seq_model i_csi_seq_model (.pclk, .op_valid, .op_code, .instr_done,
    .irq_event);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      $display("[FAIL] %0t no pready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input csi_pkg::csi_op_e c, input logic d,
      input logic [7:0] e);
    i_csi_seq_model.issue(c, d, e);
    @(negedge pclk);
  endtask
  task automatic alu(input logic w, input logic [7:0] m,
      input logic [4:0] f, input logic [2:0] b);
    @(posedge pclk);
    alu_wr <= w;
    alu_flag_mask <= m;
    {alu_h, alu_v, alu_n, alu_z, alu_c} <= f;
    bit_sel <= b;
    @(posedge pclk);
    alu_wr <= 1'b0;
    alu_flag_mask <= 8'h00;
    @(negedge pclk);
  endtask
  task automatic wait_take();
    int n;
    n = 0;
    while (irq_take !== 1'b1 && n < 12) begin
      @(negedge pclk);
      n++;
    end
    chk(irq_take, 32'h1);
  endtask
  task automatic t_stack();
    chk(reset_vector, 32'h0);
    apb(1'b0, `CSI_ADDR_SP_LO, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, `CSI_ADDR_SP_HI, 32'h04);
    apb(1'b1, `CSI_ADDR_SP_LO, 32'h60);
    apb(1'b0, `CSI_ADDR_SP_HI, 32'h0);
    chk(rdat, 32'h04);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(rerr, 32'h1);
    op(csi_pkg::CSI_OP_PUSH, 1'b0, 8'h00);
    chk(stack_ptr, 32'h045f);
    op(csi_pkg::CSI_OP_CALL, 1'b0, 8'h00);
    chk(stack_ptr, 32'h045d);
    op(csi_pkg::CSI_OP_RET, 1'b0, 8'h00);
    op(csi_pkg::CSI_OP_POP, 1'b0, 8'h00);
    chk(stack_ptr, 32'h0460);
  endtask
  task automatic t_flags();
    alu(1'b1, 8'h2f, 5'b10101, 3'd1);
    chk(ptr_x, 32'h8012);
    chk(cpu_flags_out, 32'h35);
    alu(1'b0, 8'h08, 5'b01000, 3'd1);
    chk(cpu_flags_out, 32'h2d);
    op(csi_pkg::CSI_OP_BIT_STORE, 1'b0, 8'h00);
    chk(cpu_flags_out, 32'h6d);
    alu(1'b0, 8'h00, 5'b00000, 3'd0);
    op(csi_pkg::CSI_OP_BIT_LOAD, 1'b0, 8'h00);
    chk(rd_word, 32'h8013);
  endtask
  task automatic t_irq();
    apb(1'b1, `CSI_ADDR_IRQ_EN, 32'h0a);
    op(csi_pkg::CSI_OP_NONE, 1'b0, 8'h2a);
    op(csi_pkg::CSI_OP_NONE, 1'b1, 8'h00);
    chk(seq_busy, 32'h0);
    apb(1'b1, `CSI_ADDR_IRQ_FLAG, 32'h20);
    apb(1'b0, `CSI_ADDR_IRQ_FLAG, 32'h0);
    chk(rdat, 32'h0a);
    op(csi_pkg::CSI_OP_SEI, 1'b0, 8'h00);
    op(csi_pkg::CSI_OP_NONE, 1'b1, 8'h00);
    wait_take();
    chk(irq_vector, 32'h0004);
    chk(stack_ptr, 32'h045e);
    apb(1'b0, `CSI_ADDR_IRQ_FLAG, 32'h0);
    chk(rdat, 32'h08);
    apb(1'b1, `CSI_ADDR_CTRL, 32'h1);
    op(csi_pkg::CSI_OP_IRQ_RET, 1'b1, 8'h00);
    chk(cpu_flags_out[7], 32'h1);
    op(csi_pkg::CSI_OP_NONE, 1'b1, 8'h00);
    chk(seq_busy, 32'h0);
    op(csi_pkg::CSI_OP_NONE, 1'b1, 8'h00);
    wait_take();
    chk(irq_vector, 32'h1c08);
    op(csi_pkg::CSI_OP_IRQ_RET, 1'b1, 8'h00);
  endtask
  task automatic t_guard();
    op(csi_pkg::CSI_OP_CLI, 1'b1, 8'h02);
    op(csi_pkg::CSI_OP_NONE, 1'b1, 8'h00);
    chk(seq_busy, 32'h0);
    @(posedge pclk);
    app_lock_bit <= 1'b1;
    boot_reset_fuse <= 1'b1;
    op(csi_pkg::CSI_OP_SEI, 1'b0, 8'h00);
    op(csi_pkg::CSI_OP_NONE, 1'b1, 8'h00);
    chk(seq_busy, 32'h0);
    chk(reset_vector, 32'h1c00);
    @(posedge pclk);
    app_lock_bit <= 1'b0;
    op(csi_pkg::CSI_OP_NONE, 1'b1, 8'h00);
    wait_take();
    chk(irq_vector, 32'h1c04);
  endtask
  initial begin
    {psel, penable, pwrite, alu_wr, alu_c, alu_z, alu_n, alu_v} = '0;
    {alu_h, boot_reset_fuse, app_lock_bit, bit_sel, paddr} = '0;
    {pwdata, alu_flag_mask} = '0;
    alu_wide = 1'b1;
    alu_dst = 5'd26;
    alu_result = 16'h8012;
    rd_a_idx = 5'd26;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_stack();
    t_flags();
    t_irq();
    t_guard();
    tally_and_finish();
  end
endmodule // csi_core_tb_top
